// ### rtl/cps_seq.sv
// start-up, shutdown and fault sequencer of the charge pump converter
`timescale 1ns/10ps

// What this block does
// - grounded direction strap drives internal clock out
// - floating strap takes external clock, else internal
// - straps sampled once before pump starts
// - power-on request active high with hysteresis
// - input lockout releases high, trips with hysteresis
// - adaptive pre-charge before soft start
// - soft start current limited until output ok
// - release output-ok as soft start ends
// - soft-start timeout latches off until toggle
// - output-ok is open-drain pull-down only
// - output-ok held low keeps soft start
// - shared output-ok, full power after all
// - disabled device never pulls output-ok low
// - hold output-ok low during shutdown hold
// - release output-ok only when off or running fault-free
// - pump clock is half the shared clock
// - watchdog falls back to internal clock
// - fault detectors act within microseconds
// - output short latches off, output-ok low
// - over-current cools down then restarts
// - lockout or over-temperature holds pump off
module cps_seq #(
	parameter logic [cps_pkg::TMR_W-1:0] SS_TO_CYC = cps_pkg::SS_TO_CYC,
	parameter logic [cps_pkg::TMR_W-1:0] SHUT_CYC  = cps_pkg::SHUT_CYC,
	parameter logic [cps_pkg::TMR_W-1:0] COOL_CYC  = cps_pkg::COOL_CYC
) (
	input  wire logic                clk_i,
	input  wire logic                srst_i,
	input  wire cps_pkg::cps_flags_t flags_i,
	input  wire logic                clock_direction_select_i,
	input  wire logic                int_osc_i,
	input  wire logic                sync_clk_i,
	output logic                     sync_clk_o,
	output logic                     sync_clk_oe_o,
	input  wire logic                output_ok_line_i,
	output logic                     output_ok_line_o,
	output logic                     output_ok_line_oe_o,
	output logic                     pump_clk_o,
	output logic                     ext_clk_used_o,
	output cps_pkg::cps_ctl_t        ctl_o,
	output cps_pkg::cps_state_t      state_o
);

	cps_pkg::cps_state_t       state_q;
	cps_pkg::cps_state_t       state_d;
	cps_pkg::cps_ctl_t         ctl_q;
	cps_pkg::cps_ctl_t         ctl_d;
	logic                      en_q;
	logic                      en_d;
	logic                      lock_q;
	logic                      lock_d;
	logic                      pull_q;
	logic                      pull_d;
	logic                      en_fall;
	logic                      running;
	logic                      fault_hold;
	logic                      cfg_sample;
	logic                      tmr_load;
	logic                      tmr_done;
	logic                      quiet;
	logic [cps_pkg::TMR_W-1:0] tmr_val;

	// pull-down wanted for a given state
	function automatic logic pull_low(
		input cps_pkg::cps_state_t s,
		input logic                ok
	);
		case (s)
			cps_pkg::ST_OFF:  pull_low = 1'b0;
			cps_pkg::ST_FULL: pull_low = 1'b0;
			cps_pkg::ST_SOFT: pull_low = ~ok;
			default:          pull_low = 1'b1;
		endcase
	endfunction : pull_low

	// timer reload value for the state being entered
	function automatic logic [cps_pkg::TMR_W-1:0] phase_time(
		input cps_pkg::cps_state_t s
	);
		case (s)
			cps_pkg::ST_SOFT: phase_time = SS_TO_CYC;
			cps_pkg::ST_SHUT: phase_time = SHUT_CYC;
			default:          phase_time = COOL_CYC;
		endcase
	endfunction : phase_time

	// request and lockout comparators with hysteresis
	assign en_d = flags_i.en_hi | (en_q & flags_i.en_lo);
	assign lock_d = ~flags_i.rail_lo
		| (lock_q & ~flags_i.rail_hi);

	// event and condition decode
	assign en_fall    = en_q & ~en_d;
	assign fault_hold = lock_q | flags_i.over_temp;
	assign running    = (state_q == cps_pkg::ST_PRE)
		| (state_q == cps_pkg::ST_SOFT)
		| (state_q == cps_pkg::ST_FULL);
	assign quiet      = en_d & ~flags_i.short_flt & ~flags_i.oc_flt
		& ~fault_hold;
	assign cfg_sample = (state_q == cps_pkg::ST_OFF) & en_d;

	// timer is reloaded on entry to each timed phase
	assign tmr_load = (state_d != state_q)
		& ((state_d == cps_pkg::ST_SOFT)
		| (state_d == cps_pkg::ST_SHUT)
		| (state_d == cps_pkg::ST_COOL));
	assign tmr_val  = phase_time(state_d);

	// outputs registered from next state
	assign pull_d  = pull_low(state_d, flags_i.out_ok);
	assign ctl_d.precharge   = state_d == cps_pkg::ST_PRE;
	assign ctl_d.soft_limit  = state_d == cps_pkg::ST_SOFT;
	assign ctl_d.full_power  = state_d == cps_pkg::ST_FULL;
	assign ctl_d.pump_run    = (state_d == cps_pkg::ST_SOFT)
		| (state_d == cps_pkg::ST_FULL);
	assign ctl_d.latched_off = state_d == cps_pkg::ST_LATCH;

	// open drain: only ever pulls low, oe low while pulling
	assign output_ok_line_o    = 1'b0;
	assign output_ok_line_oe_o = ~pull_q;
	assign ctl_o               = ctl_q;
	assign state_o             = state_q;

	// next state: normal sequence, then faults, then disable
	always_comb begin
		state_d = state_q;
		case (state_q)
			cps_pkg::ST_OFF: begin
				if (en_d)
					state_d = cps_pkg::ST_WAIT;
			end
			cps_pkg::ST_WAIT: begin
				if (!fault_hold)
					state_d = cps_pkg::ST_PRE;
			end
			cps_pkg::ST_PRE: begin
				if (flags_i.pre_done)
					state_d = cps_pkg::ST_SOFT;
			end
			cps_pkg::ST_SOFT: begin
				if (tmr_done && !flags_i.out_ok)
					state_d = cps_pkg::ST_LATCH;
				else if (flags_i.out_ok && output_ok_line_i)
					state_d = cps_pkg::ST_FULL;
			end
			cps_pkg::ST_FULL: begin
				if (!flags_i.out_ok)
					state_d = cps_pkg::ST_COOL;
				else if (!output_ok_line_i)
					state_d = cps_pkg::ST_SOFT;
			end
			cps_pkg::ST_COOL: begin
				if (tmr_done)
					state_d = cps_pkg::ST_WAIT;
			end
			cps_pkg::ST_LATCH: begin
				state_d = cps_pkg::ST_LATCH;
			end
			cps_pkg::ST_SHUT: begin
				if (en_d)
					state_d = cps_pkg::ST_WAIT;
				else if (tmr_done)
					state_d = cps_pkg::ST_OFF;
			end
			default: begin
				state_d = cps_pkg::ST_OFF;
			end
		endcase
		// detectors act in the cycle they report
		if (running) begin
			if (flags_i.short_flt)
				state_d = cps_pkg::ST_LATCH;
			else if (flags_i.oc_flt)
				state_d = cps_pkg::ST_COOL;
			else if (fault_hold)
				state_d = cps_pkg::ST_WAIT;
		end
		// request drop wins over everything
		if (en_fall && state_q != cps_pkg::ST_OFF)
			state_d = cps_pkg::ST_SHUT;
	end

	// state and control registers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_q <= cps_pkg::ST_OFF;
			en_q    <= cps_pkg::EN_RST;
			lock_q  <= cps_pkg::LOCK_RST;
			pull_q  <= cps_pkg::PULL_RST;
			ctl_q   <= cps_pkg::CTL_RST;
		end else begin
			state_q <= state_d;
			en_q    <= en_d;
			lock_q  <= lock_d;
			pull_q  <= pull_d;
			ctl_q   <= ctl_d;
		end
	end

	// phase timer: soft-start timeout, shutdown hold, cool-down
	cps_timer u_timer (
		.clk_i   (clk_i),
		.srst_i  (srst_i),
		.load_i  (tmr_load),
		.value_i (tmr_val),
		.done_o  (tmr_done)
	);

	// clock source and pump clock
	cps_clk_sel u_clk (
		.clk_i      (clk_i),
		.srst_i     (srst_i),
		.sample_i   (cfg_sample),
		.dir_i      (clock_direction_select_i),
		.run_i      (ctl_q.pump_run),
		.int_osc_i  (int_osc_i),
		.sync_i     (sync_clk_i),
		.sync_o     (sync_clk_o),
		.sync_oe_o  (sync_clk_oe_o),
		.pump_clk_o (pump_clk_o),
		.ext_used_o (ext_clk_used_o)
	);

	// checks on the sequence
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	off_release_a: assert property (
		state_q == cps_pkg::ST_OFF |-> output_ok_line_oe_o)
		else $error("output-ok pulled while disabled");
	shut_entry_a: assert property (
		en_fall && state_q != cps_pkg::ST_OFF
		|=> state_q == cps_pkg::ST_SHUT && !output_ok_line_oe_o)
		else $error("request drop did not start shutdown hold");
	shut_end_a: assert property (
		state_q == cps_pkg::ST_SHUT && tmr_done && !en_d
		|=> state_q == cps_pkg::ST_OFF && output_ok_line_oe_o)
		else $error("shutdown hold did not release output-ok");
	short_latch_a: assert property (
		running && flags_i.short_flt && !en_fall
		|=> ctl_o.latched_off && !output_ok_line_oe_o
		&& !ctl_o.pump_run)
		else $error("short did not latch off");
	latch_stay_a: assert property (
		state_q == cps_pkg::ST_LATCH && en_d
		|=> state_q == cps_pkg::ST_LATCH)
		else $error("latched state left without toggle");
	timeout_a: assert property (
		state_q == cps_pkg::ST_SOFT && tmr_done && !flags_i.out_ok
		&& quiet |=> state_q == cps_pkg::ST_LATCH)
		else $error("soft-start timeout missed");
	soft_hold_a: assert property (
		state_q == cps_pkg::ST_SOFT && !output_ok_line_i
		|=> !ctl_o.full_power)
		else $error("full power while output-ok held low");
	full_back_a: assert property (
		state_q == cps_pkg::ST_FULL && !output_ok_line_i
		&& flags_i.out_ok && quiet
		|=> ctl_o.soft_limit && output_ok_line_oe_o)
		else $error("external pull-down did not force soft start");
	oc_cool_a: assert property (
		running && flags_i.oc_flt && !flags_i.short_flt && en_d
		##1 en_d |-> state_q == cps_pkg::ST_COOL [*2])
		else $error("over-current did not start cool-down");
	wait_hold_a: assert property (
		state_q == cps_pkg::ST_WAIT && fault_hold
		|=> !ctl_o.precharge)
		else $error("pre-charge began under lockout");
	soft_rel_a: assert property (
		state_q == cps_pkg::ST_SOFT && flags_i.out_ok && quiet
		|=> output_ok_line_oe_o)
		else $error("output-ok not released at threshold");
	pre_soft_a: assert property (
		state_q == cps_pkg::ST_PRE && flags_i.pre_done && quiet
		|=> ctl_o.soft_limit && ctl_o.pump_run)
		else $error("soft start did not follow pre-charge");
	en_level_a: assert property (
		state_q == cps_pkg::ST_OFF && !flags_i.en_hi
		|=> state_q == cps_pkg::ST_OFF)
		else $error("lower enable level alone started the sequencer");
	full_gate_a: assert property (
		ctl_o.full_power |-> output_ok_line_oe_o)
		else $error("full power while pulling output-ok low");
	lock_stop_a: assert property (
		lock_q && running |=> !ctl_o.pump_run)
		else $error("pump kept running under input lockout");

	reach_full_c: cover property (state_q == cps_pkg::ST_FULL);
	reach_latch_c: cover property (state_q == cps_pkg::ST_LATCH);
	reach_cool_c: cover property (state_q == cps_pkg::ST_COOL);
	shut_off_c: cover property (
		state_q == cps_pkg::ST_SHUT ##1 state_q == cps_pkg::ST_OFF);
	soft_back_c: cover property (
		state_q == cps_pkg::ST_FULL ##1 state_q == cps_pkg::ST_SOFT);

endmodule : cps_seq

// ### rtl/cps_pkg.sv
// shared constants and types for the charge pump start-up sequencer
package cps_pkg;

	// clock rate
	localparam int CLK_HZ   = 50_000_000;
	localparam int CYC_P_MS = CLK_HZ / 1000;
	localparam int CYC_P_US = CLK_HZ / 1_000_000;

	// times in their own units
	localparam int SS_TO_MS = 100;  // soft start timeout
	localparam int SHUT_MS  = 60;   // output-ok hold after disable
	localparam int COOL_MS  = 10;   // over-current cool-down
	localparam int WDOG_US  = 20;   // external clock watchdog

	// timer and watchdog widths
	localparam int TMR_W  = 23;
	localparam int WDOG_W = 10;

	// cycle counts
	localparam logic [TMR_W-1:0] SS_TO_CYC =
		TMR_W'(SS_TO_MS * CYC_P_MS);
	localparam logic [TMR_W-1:0] SHUT_CYC =
		TMR_W'(SHUT_MS * CYC_P_MS);
	localparam logic [TMR_W-1:0] COOL_CYC =
		TMR_W'(COOL_MS * CYC_P_MS);
	localparam logic [WDOG_W-1:0] WDOG_CYC =
		WDOG_W'(WDOG_US * CYC_P_US);

	// clock direction strap: grounded drives the clock out
	localparam logic DIR_OUT = 1'b0;

	// reset values
	localparam logic DIR_RST  = 1'b1;
	localparam logic EN_RST   = 1'b0;
	localparam logic LOCK_RST = 1'b1;
	localparam logic PULL_RST = 1'b0;
	localparam logic [TMR_W-1:0] TMR_RST = '0;

	// sequencer states, gray along the start-up path
	typedef enum logic [2:0] {
		ST_OFF   = 3'h0,
		ST_WAIT  = 3'h1,
		ST_PRE   = 3'h3,
		ST_SOFT  = 3'h2,
		ST_FULL  = 3'h6,
		ST_COOL  = 3'h7,
		ST_LATCH = 3'h5,
		ST_SHUT  = 3'h4
	} cps_state_t;

	// analog comparator results, already synchronous
	typedef struct packed {
		logic en_hi;      // request above upper enable level
		logic en_lo;      // request above lower enable level
		logic rail_hi;    // input_rail above release level
		logic rail_lo;    // input_rail above release minus hysteresis
		logic over_temp;  // over-temperature detector
		logic pre_done;   // flying capacitors balanced
		logic out_ok;     // output_rail above output-ok threshold
		logic short_flt;  // output short-circuit detector
		logic oc_flt;     // over-current detector
	} cps_flags_t;

	// power stage controls
	typedef struct packed {
		logic precharge;   // pre-charge phase active
		logic soft_limit;  // input current limited for soft start
		logic full_power;  // full load allowed
		logic pump_run;    // charge pump switching
		logic latched_off; // latched fault, needs request toggle
	} cps_ctl_t;

	localparam cps_ctl_t CTL_RST = '0;

endpackage : cps_pkg

// ### rtl/cps_timer.sv
// one-shot down counter shared by the sequencer phases
`timescale 1ns/10ps
module cps_timer (
	input  wire logic                     clk_i,
	input  wire logic                     srst_i,
	input  wire logic                     load_i,
	input  wire logic [cps_pkg::TMR_W-1:0] value_i,
	output logic                          done_o
);

	logic [cps_pkg::TMR_W-1:0] cnt_q;
	logic                      armed_q;
	logic                      tick;

	// counts only while armed and not yet at zero
	assign tick   = armed_q & (cnt_q != '0);
	assign done_o = armed_q & (cnt_q == '0);

	// done stays high until the next load
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cnt_q   <= cps_pkg::TMR_RST;
			armed_q <= 1'b0;
		end else if (load_i) begin
			cnt_q   <= value_i;
			armed_q <= 1'b1;
		end else if (tick) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

endmodule : cps_timer

// ### rtl/cps_clk_sel.sv
// clock source selection, external clock watchdog, pump clock divider
`timescale 1ns/10ps
module cps_clk_sel (
	input  wire logic clk_i,
	input  wire logic srst_i,
	input  wire logic sample_i,
	input  wire logic dir_i,
	input  wire logic run_i,
	input  wire logic int_osc_i,
	input  wire logic sync_i,
	output logic      sync_o,
	output logic      sync_oe_o,
	output logic      pump_clk_o,
	output logic      ext_used_o
);

	logic                       dir_q;
	logic                       osc_q;
	logic                       sync_q;
	logic                       sel_q;
	logic                       oe_q;
	logic                       pump_q;
	logic [cps_pkg::WDOG_W-1:0] wd_q;
	logic                       sync_edge;
	logic                       wd_full;
	logic                       ext_ok;
	logic                       sel;
	logic                       sel_rise;

	// watchdog: no edge within the window falls back to internal
	assign sync_edge = sync_i ^ sync_q;
	assign wd_full   = (wd_q == cps_pkg::WDOG_CYC);
	assign ext_ok    = (dir_q != cps_pkg::DIR_OUT) & ~wd_full;
	assign sel       = ext_ok ? sync_q : osc_q;
	assign sel_rise  = sel & ~sel_q;

	assign sync_o     = osc_q;
	assign sync_oe_o  = oe_q;
	assign pump_clk_o = pump_q;
	assign ext_used_o = ext_ok;

	// strap captured on leaving off, before the pump runs; a restart from shutdown hold keeps it
	always_ff @(posedge clk_i) begin
		if (srst_i)
			dir_q <= cps_pkg::DIR_RST;
		else if (sample_i)
			dir_q <= dir_i;
	end

	// pin drive: oe low drives the internal clock out
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			oe_q  <= 1'b1;
			osc_q <= 1'b0;
		end else begin
			oe_q  <= dir_q != cps_pkg::DIR_OUT;
			osc_q <= int_osc_i;
		end
	end

	// watchdog counter, saturating
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sync_q <= 1'b0;
			wd_q   <= cps_pkg::WDOG_CYC;
		end else begin
			sync_q <= sync_i;
			if (sync_edge)
				wd_q <= '0;
			else if (!wd_full)
				wd_q <= wd_q + 1'b1;
		end
	end

	// pump clock toggles on each rising edge of the chosen clock
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sel_q  <= 1'b0;
			pump_q <= 1'b0;
		end else begin
			sel_q <= sel;
			if (!run_i)
				pump_q <= 1'b0;
			else if (sel_rise)
				pump_q <= ~pump_q;
		end
	end

	pump_half_a: assert property (@(posedge clk_i) disable iff (srst_i)
		run_i && sel_rise |=> pump_q != $past(pump_q))
		else $error("pump clock missed a toggle");
	cfg_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
		!sample_i |=> $stable(dir_q))
		else $error("clock direction changed without sampling");
	wdog_fall_a: assert property (@(posedge clk_i) disable iff (srst_i)
		!sync_edge [*8] |-> ##1 (wd_q >= 10'h008 || !ext_ok || sel == sync_q))
		else $error("watchdog count lost");

endmodule : cps_clk_sel

// ### verif/cps_far.sv
// far side model: controller, parallel module, pull-up and pull-down
`timescale 1ns/10ps
module cps_far (
	input  wire logic clk_i,
	input  wire logic hold_low_i,
	input  wire logic ext_run_i,
	input  wire logic dut_ok_oe_i,
	input  wire logic dut_ok_i,
	input  wire logic dut_clk_i,
	input  wire logic dut_clk_oe_i,
	output logic      ok_line_o,
	output logic      sync_line_o
);
	logic [1:0] div_q = 2'h0;
	logic       ext_q = 1'b0;

	// external clock of six cycles, still while stopped
	always_ff @(posedge clk_i) begin
		div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
		if (!ext_run_i)
			ext_q <= 1'b0;
		else if (div_q == 2'h2)
			ext_q <= ~ext_q;
	end

	// wired output-ok: pull-up unless anyone pulls low
	assign ok_line_o = (dut_ok_oe_i | dut_ok_i) & ~hold_low_i;
	// shared clock pin: resistor to ground when nobody drives
	assign sync_line_o = !dut_clk_oe_i ? dut_clk_i : ext_q;
endmodule : cps_far

// ### verif/cps_seq_tb.sv
// self-checking bench of the start-up sequencer
`timescale 1ns/10ps
module cps_seq_tb;
	logic                clk_i;
	logic                srst_i;
	cps_pkg::cps_flags_t flags;
	cps_pkg::cps_ctl_t   ctl;
	cps_pkg::cps_state_t state;
	logic                strap;
	logic [1:0]          osc_q = 2'h0;
	logic                ok_drv, osc_d;
	logic                hold, ext_run;
	logic                ok_line, ok_oe, sync_line, sync_out, sync_oe;
	logic                pump, ext_used;
	int                  failures;
	int                  samples_checked;
	int                  per;

	cps_seq #(.SS_TO_CYC(23'h0000C8), .SHUT_CYC(23'h000064),
		.COOL_CYC(23'h000032)) u_dut (
		.clk_i(clk_i), .srst_i(srst_i), .flags_i(flags),
		.clock_direction_select_i(strap), .int_osc_i(osc_q[1]),
		.sync_clk_i(sync_line), .sync_clk_o(sync_out),
		.sync_clk_oe_o(sync_oe), .output_ok_line_i(ok_line),
		.output_ok_line_o(ok_drv), .output_ok_line_oe_o(ok_oe),
		.pump_clk_o(pump), .ext_clk_used_o(ext_used), .ctl_o(ctl),
		.state_o(state));

	cps_far u_far (.clk_i(clk_i), .hold_low_i(hold), .ext_run_i(ext_run),
		.dut_ok_oe_i(ok_oe), .dut_ok_i(ok_drv), .dut_clk_i(sync_out),
		.dut_clk_oe_i(sync_oe), .ok_line_o(ok_line),
		.sync_line_o(sync_line));

	// 50 MHz clock and a four-cycle internal oscillator
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge clk_i) osc_q <= osc_q + 2'h1;
	always @(posedge clk_i) osc_d <= osc_q[1]; // pin copy, one edge late

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// wait for a state under a bounded count, then compare
	task automatic wst(input cps_pkg::cps_state_t s, input int lim);
		int n;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (state !== s && n < lim);
		chk(8'(state), 8'(s));
	endtask : wst

	// one shared request drives both enable levels
	task automatic go(input logic v);
		@(posedge clk_i);
		flags.en_hi <= v;
		flags.en_lo <= v;
	endtask : go

	task automatic lvl(input logic v, output int n);
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (pump !== v && n < 40);
	endtask : lvl

	// cycles between two rising edges of the pump clock
	task automatic pump_per(output int p);
		int a;
		int b;
		lvl(1'b0, a);
		lvl(1'b1, a);
		lvl(1'b0, a);
		lvl(1'b1, b);
		p = a + b;
	endtask : pump_per

	// start to soft start; output stays unloaded until line high
	task automatic to_soft;
		go(1'b1);
		wst(cps_pkg::ST_PRE, 6);
		chk({7'h0, ctl.precharge}, 8'h01);
		chk({7'h0, ok_oe}, 8'h00);
		@(posedge clk_i) flags.pre_done <= 1'b1;
		wst(cps_pkg::ST_SOFT, 4);
		chk({6'h0, ctl.soft_limit, ctl.pump_run}, 8'h03);
		chk({7'h0, ok_oe}, 8'h00);
	endtask : to_soft

	task automatic give_verdict;
		if (failures == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict

	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		give_verdict();
	end

	initial begin
		failures = 0;
		samples_checked = 0;
		srst_i = 1'b1;
		flags = '0;
		strap = 1'b0;
		hold = 1'b0;
		ext_run = 1'b0;
		repeat (5) @(posedge clk_i);
		srst_i <= 1'b0;
		@(negedge clk_i);
		chk({state, ctl}, 8'h00);
		chk({5'h0, ok_drv, ok_oe, sync_oe}, 8'h03);
		// lower level alone never enables, line left alone
		@(posedge clk_i) flags.en_lo <= 1'b1;
		repeat (6) @(negedge clk_i);
		chk({5'h0, state}, 8'h00);
		chk({7'h0, ok_oe}, 8'h01);
		@(posedge clk_i) flags.rail_hi <= 1'b1;
		@(posedge clk_i) flags.rail_lo <= 1'b1;
		to_soft();
		chk({7'h0, sync_oe}, 8'h00);
		@(posedge clk_i) flags.out_ok <= 1'b1;
		wst(cps_pkg::ST_FULL, 4);
		chk({6'h0, ctl.full_power, ok_oe}, 8'h03);
		pump_per(per);
		chk(8'(per), 8'h08);
		// the shared pin carries the internal clock
		repeat (4) begin
			@(negedge clk_i);
			chk({7'h0, sync_line}, {7'h0, osc_d});
		end
		// strap changes after start are ignored
		@(posedge clk_i) strap <= 1'b1;
		repeat (5) @(negedge clk_i);
		chk({7'h0, sync_oe}, 8'h00);
		// another agent holds output-ok low
		@(posedge clk_i) hold <= 1'b1;
		wst(cps_pkg::ST_SOFT, 4);
		chk({7'h0, ctl.full_power}, 8'h00);
		@(posedge clk_i) hold <= 1'b0;
		wst(cps_pkg::ST_FULL, 4);
		// shutdown hold then release
		go(1'b0);
		wst(cps_pkg::ST_SHUT, 4);
		@(posedge clk_i);
		flags.pre_done <= 1'b0;
		flags.out_ok <= 1'b0;
		repeat (95) @(negedge clk_i);
		chk({7'h0, ok_oe}, 8'h00);
		wst(cps_pkg::ST_OFF, 10);
		chk({7'h0, ok_oe}, 8'h01);
		// floating strap with external clock, soft-start timeout
		@(posedge clk_i) ext_run <= 1'b1;
		to_soft();
		repeat (190) @(negedge clk_i);
		chk(8'(state), 8'(cps_pkg::ST_SOFT));
		wst(cps_pkg::ST_LATCH, 20);
		chk({6'h0, ctl.latched_off, ok_oe}, 8'h02);
		repeat (10) @(negedge clk_i);
		chk(8'(state), 8'(cps_pkg::ST_LATCH));
		go(1'b0);
		wst(cps_pkg::ST_SHUT, 4);
		@(posedge clk_i) flags.pre_done <= 1'b0;
		to_soft();
		@(posedge clk_i) flags.out_ok <= 1'b1;
		wst(cps_pkg::ST_FULL, 4);
		chk({6'h0, ext_used, sync_oe}, 8'h03);
		pump_per(per);
		chk(8'(per), 8'h0C);
		// external clock lost, then resumed
		@(posedge clk_i) ext_run <= 1'b0;
		repeat (1010) @(negedge clk_i);
		chk({7'h0, ext_used}, 8'h00);
		pump_per(per);
		chk(8'(per), 8'h08);
		@(posedge clk_i) ext_run <= 1'b1;
		repeat (30) @(negedge clk_i);
		chk({7'h0, ext_used}, 8'h01);
		// over-current cool-down and automatic restart
		@(posedge clk_i) flags.oc_flt <= 1'b1;
		wst(cps_pkg::ST_COOL, 4);
		chk({6'h0, ctl.pump_run, ok_oe}, 8'h00);
		@(posedge clk_i) flags.oc_flt <= 1'b0;
		repeat (45) @(negedge clk_i);
		chk(8'(state), 8'(cps_pkg::ST_COOL));
		wst(cps_pkg::ST_FULL, 16);
		// output short latches off
		@(posedge clk_i) flags.short_flt <= 1'b1;
		wst(cps_pkg::ST_LATCH, 4);
		chk({6'h0, ctl.latched_off, ok_oe}, 8'h02);
		@(posedge clk_i) flags.short_flt <= 1'b0;
		// lockout and over-temperature hold the pump off
		go(1'b0);
		wst(cps_pkg::ST_OFF, 120);
		@(posedge clk_i);
		flags.pre_done <= 1'b0;
		flags.rail_hi <= 1'b0;
		flags.rail_lo <= 1'b0;
		flags.over_temp <= 1'b1;
		go(1'b1);
		@(posedge clk_i) flags.rail_lo <= 1'b1;
		repeat (10) @(negedge clk_i);
		chk({state, ctl}, {cps_pkg::ST_WAIT, 5'h00});
		@(posedge clk_i) flags.rail_hi <= 1'b1;
		repeat (5) @(negedge clk_i);
		chk(8'(state), 8'(cps_pkg::ST_WAIT));
		@(posedge clk_i) flags.over_temp <= 1'b0;
		wst(cps_pkg::ST_PRE, 6);
		@(posedge clk_i) flags.rail_hi <= 1'b0;
		repeat (4) @(negedge clk_i);
		chk(8'(state), 8'(cps_pkg::ST_PRE));
		@(posedge clk_i) flags.rail_lo <= 1'b0;
		wst(cps_pkg::ST_WAIT, 4);
		give_verdict();
	end
endmodule : cps_seq_tb
